// >>> include/rcr_pkg.sv
package rcr_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_MAIN_SUPPLY_STATUS = 12'h428;
   localparam logic [11:0] OFS_POWER_DOWN_CONTROL = 12'h500;
   localparam logic [11:0] OFS_SUPPLY_DROP_CONFIG = 12'h510;
   localparam logic [11:0] OFS_IRQ_STATUS         = 12'h600;
   localparam logic [11:0] OFS_IRQ_MASK           = 12'h604;
   localparam logic [11:0] OFS_CMP_STATE          = 12'h608;
   localparam logic [11:0] OFS_MAIN_REG_SWITCH    = 12'h704;
   localparam logic [11:0] OFS_RADIO_REG_SWITCH   = 12'h904;
   localparam logic [11:0] OFS_HIGH_REG_SWITCH    = 12'hb00;

   // ---------------------------------------------------------------
   // Field positions and masks
   // ---------------------------------------------------------------
   localparam int          STATUS_HV_BIT = 0;
   localparam int          PD_BIT        = 0;
   localparam int          SW_EN_BIT     = 0;
   localparam int          CFG_EN_BIT    = 0;
   localparam int          CFG_NV_LSB    = 1;
   localparam int          CFG_NV_MSB    = 4;
   localparam int          CFG_HV_LSB    = 8;
   localparam int          CFG_HV_MSB    = 11;
   localparam logic [31:0] CFG_MASK      = 32'h00000f1f;
   localparam int          IRQ_WARN_BIT  = 0;
   localparam int          IRQ_MODE_BIT  = 1;
   localparam int          IRQ_W         = 2;
   localparam int          STATE_BELOW_BIT  = 0;
   localparam int          STATE_ACTIVE_BIT = 1;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [31:0]      CFG_RST      = 32'h00000000;
   localparam logic             SW_EN_RST    = 1'h0;
   localparam logic [IRQ_W-1:0] IRQ_RST      = 2'h0;

   // ---------------------------------------------------------------
   // Comparator thresholds, in tenths of a volt
   // ---------------------------------------------------------------
   localparam int         SUP_W       = 7;
   localparam int         CODE_W      = 4;
   localparam int         EXT_LVL_W   = 4;
   localparam int         PIN_W       = SUP_W + 2;
   localparam logic [3:0] NV_CODE_MIN = 4'h6;
   localparam logic [6:0] NV_BASE_DV  = 7'h0d;
   localparam logic [6:0] HV_BASE_DV  = 7'h1b;

endpackage : rcr_pkg

// >>> include/rcr_cmp_if.sv
`timescale 1ns/10ps
interface rcr_cmp_if;
   import rcr_pkg::*;

   logic              enable;
   logic [CODE_W-1:0] nv_code;
   logic [CODE_W-1:0] hv_code;
   logic              hv_mode;
   logic              hf_run;
   logic              sys_off;
   logic [SUP_W-1:0]  supply;
   logic              below;
   logic              active;
   logic              warn;

   modport ctrl (output enable, nv_code, hv_code, hv_mode, hf_run, sys_off, supply,
                 input  below, active, warn);
   modport cmp  (input  enable, nv_code, hv_code, hv_mode, hf_run, sys_off, supply,
                 output below, active, warn);

endinterface : rcr_cmp_if

// >>> hdl/rcr_supply_cmp.sv
`timescale 1ns/10ps
module rcr_supply_cmp
   import rcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   rcr_cmp_if.cmp   cmp
);

   logic [CODE_W-1:0] nv_eff;
   logic [SUP_W-1:0]  thr_dv;
   logic              active;
   logic              below_now;
   logic              below_r;
   logic              active_r;
   logic              warn_r;

   // ---------------------------------------------------------------
   // Threshold selection and comparison
   // ---------------------------------------------------------------
   // Normal-mode codes under the lowest legal code act as that code.
   always_comb begin
      nv_eff = (cmp.nv_code < NV_CODE_MIN) ? NV_CODE_MIN : cmp.nv_code;
      if (cmp.hv_mode) begin
         thr_dv = SUP_W'({3'h0, cmp.hv_code}) + HV_BASE_DV;
      end else begin
         thr_dv = SUP_W'({3'h0, nv_eff}) + NV_BASE_DV;
      end
      active    = cmp.enable & cmp.hf_run & ~cmp.sys_off;
      below_now = active & (cmp.supply < thr_dv);
   end

   // ---------------------------------------------------------------
   // Warning event on entry into the below-threshold condition
   // ---------------------------------------------------------------
   // An edge on the gated condition also catches enabling while low and
   // raising the threshold above the present supply.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         below_r  <= 1'h0;
         active_r <= 1'h0;
         warn_r   <= 1'h0;
      end else begin
         below_r  <= below_now;
         active_r <= active;
         warn_r   <= below_now & ~below_r;
      end
   end

   assign cmp.below  = below_r;
   assign cmp.active = active_r;
   assign cmp.warn   = warn_r;

endmodule : rcr_supply_cmp

// >>> hdl/rcr_regs.sv
`timescale 1ns/10ps
module rcr_regs
   import rcr_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 high_voltage_mode,
   input  wire logic                 high_freq_clock_running,
   input  wire logic [SUP_W-1:0]     supply_level,
   input  wire logic [EXT_LVL_W-1:0] external_supply_level_cfg,
   output logic                      main_regulator_switch_en,
   output logic                      radio_regulator_switch_en,
   output logic                      high_voltage_regulator_switch_en,
   output logic                      power_down_req,
   output logic                      supply_drop_warning_app,
   output logic                      supply_drop_warning_net,
   output logic                      nvm_write_block,
   output logic [EXT_LVL_W-1:0]      external_supply_level,
   output logic                      irq
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0] pin_s1_r;
   logic [PIN_W-1:0] pin_s2_r;
   logic [PIN_W-1:0] pin_s3_r;
   logic [PIN_W-1:0] pin_q_r;
   logic             hv_q;
   logic             hf_q;
   logic [SUP_W-1:0] sup_q;

   // The whole group moves together only when two stages agree, so the
   // comparator never sees a half-updated supply code.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
         pin_q_r  <= '0;
      end else begin
         pin_s1_r <= {high_voltage_mode, high_freq_clock_running, supply_level};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         if (pin_s2_r == pin_s3_r) begin
            pin_q_r <= pin_s3_r;
         end
      end
   end

   assign hv_q  = pin_q_r[PIN_W-1];
   assign hf_q  = pin_q_r[PIN_W-2];
   assign sup_q = pin_q_r[SUP_W-1:0];

   // ---------------------------------------------------------------
   // APB slave handshake
   // ---------------------------------------------------------------
   logic        pready_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   logic        apb_acc;
   logic        apb_done;
   logic        wr_en;
   logic [31:0] rd_data;
   logic        addr_hit;
   logic [31:0] wmask;

   assign apb_acc  = psel & penable;
   assign apb_done = apb_acc & pready_r;
   assign wr_en    = apb_done & pwrite;
   assign wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // One wait state: data and error are registered in the first access
   // cycle and the transfer completes on the following edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'h0;
      end else if (pready_r) begin
         pready_r <= 1'h0;
      end else if (apb_acc) begin
         pready_r <= 1'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'h0;
      end else if (apb_acc && !pready_r) begin
         prdata_r  <= pwrite ? 32'h00000000 : rd_data;
         pslverr_r <= ~addr_hit;
      end else if (apb_done) begin
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'h0;
      end
   end

   assign pready  = pready_r;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // ---------------------------------------------------------------
   // Retained configuration
   // ---------------------------------------------------------------
   logic [31:0] cfg_r;
   logic        main_sw_r;
   logic        radio_sw_r;
   logic        high_sw_r;
   logic        power_down_r;
   logic        hv_status_r;

   // Retained state is cleared only by the power-on reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= CFG_RST;
      end else if (wr_en && paddr == OFS_SUPPLY_DROP_CONFIG) begin
         cfg_r <= ((cfg_r & ~wmask) | (pwdata & wmask)) & CFG_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_sw_r  <= SW_EN_RST;
         radio_sw_r <= SW_EN_RST;
         high_sw_r  <= SW_EN_RST;
      end else if (wr_en && pstrb[0]) begin
         if (paddr == OFS_MAIN_REG_SWITCH) begin
            main_sw_r <= pwdata[SW_EN_BIT];
         end
         if (paddr == OFS_RADIO_REG_SWITCH) begin
            radio_sw_r <= pwdata[SW_EN_BIT];
         end
         if (paddr == OFS_HIGH_REG_SWITCH) begin
            high_sw_r <= pwdata[SW_EN_BIT];
         end
      end
   end

   // Power-down request is sticky until the next reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_down_r <= 1'h0;
      end else if (wr_en && pstrb[0] && paddr == OFS_POWER_DOWN_CONTROL && pwdata[PD_BIT]) begin
         power_down_r <= 1'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hv_status_r <= 1'h0;
      end else begin
         hv_status_r <= hv_q;
      end
   end

   assign main_regulator_switch_en         = main_sw_r;
   assign radio_regulator_switch_en        = radio_sw_r;
   assign high_voltage_regulator_switch_en = high_sw_r;
   assign power_down_req                   = power_down_r;

   // ---------------------------------------------------------------
   // Supply-drop comparator
   // ---------------------------------------------------------------
   rcr_cmp_if cmp_bus ();

   assign cmp_bus.enable  = cfg_r[CFG_EN_BIT];
   assign cmp_bus.nv_code = cfg_r[CFG_NV_MSB:CFG_NV_LSB];
   assign cmp_bus.hv_code = cfg_r[CFG_HV_MSB:CFG_HV_LSB];
   assign cmp_bus.hv_mode = hv_status_r;
   assign cmp_bus.hf_run  = hf_q;
   assign cmp_bus.sys_off = power_down_r;
   assign cmp_bus.supply  = sup_q;

   rcr_supply_cmp u_cmp (
      .clk   (pclk),
      .rst_n (presetn),
      .cmp   (cmp_bus.cmp)
   );

   logic                 warn_app_r;
   logic                 warn_net_r;
   logic                 nvm_block_r;
   logic [EXT_LVL_W-1:0] ext_lvl_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_app_r  <= 1'h0;
         warn_net_r  <= 1'h0;
         nvm_block_r <= 1'h0;
      end else begin
         warn_app_r  <= cmp_bus.warn;
         warn_net_r  <= cmp_bus.warn;
         nvm_block_r <= cmp_bus.below;
      end
   end

   // Outside high voltage mode nothing is sourced, so the level reads zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_lvl_r <= '0;
      end else begin
         ext_lvl_r <= hv_status_r ? external_supply_level_cfg : '0;
      end
   end

   assign supply_drop_warning_app = warn_app_r;
   assign supply_drop_warning_net = warn_net_r;
   assign nvm_write_block         = nvm_block_r;
   assign external_supply_level   = ext_lvl_r;

   // ---------------------------------------------------------------
   // Interrupt status and mask
   // ---------------------------------------------------------------
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_stat_nxt;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic             irq_r;

   // Only bits that were captured for the read are cleared, and a new
   // event in the clearing cycle still sets its bit.
   always_comb begin
      irq_set               = '0;
      irq_set[IRQ_WARN_BIT] = cmp_bus.warn;
      irq_set[IRQ_MODE_BIT] = hv_status_r ^ hv_q;
      irq_clr               = '0;
      if (apb_done && !pwrite && paddr == OFS_IRQ_STATUS) begin
         irq_clr = prdata_r[IRQ_W-1:0];
      end
      irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= IRQ_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= IRQ_RST;
      end else if (wr_en && pstrb[0] && paddr == OFS_IRQ_MASK) begin
         irq_mask_r <= pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'h0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   assign irq = irq_r;

   // ---------------------------------------------------------------
   // Read multiplexer
   // ---------------------------------------------------------------
   always_comb begin
      rd_data  = 32'h00000000;
      addr_hit = 1'h1;
      case (paddr)
         OFS_MAIN_SUPPLY_STATUS: rd_data[STATUS_HV_BIT] = hv_status_r;
         OFS_POWER_DOWN_CONTROL: rd_data = 32'h00000000;
         OFS_SUPPLY_DROP_CONFIG: rd_data = cfg_r;
         OFS_IRQ_STATUS:         rd_data[IRQ_W-1:0] = irq_stat_r;
         OFS_IRQ_MASK:           rd_data[IRQ_W-1:0] = irq_mask_r;
         OFS_CMP_STATE: begin
            rd_data[STATE_BELOW_BIT]  = cmp_bus.below;
            rd_data[STATE_ACTIVE_BIT] = cmp_bus.active;
         end
         OFS_MAIN_REG_SWITCH:    rd_data[SW_EN_BIT] = main_sw_r;
         OFS_RADIO_REG_SWITCH:   rd_data[SW_EN_BIT] = radio_sw_r;
         OFS_HIGH_REG_SWITCH:    rd_data[SW_EN_BIT] = high_sw_r;
         default:                addr_hit = 1'h0;
      endcase
   end

endmodule : rcr_regs

// >>> dv/rcr_regs_properties.sv
`timescale 1ns/10ps
module rcr_regs_chk
   import rcr_pkg::*;
(
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic                 pready,
   input wire logic                 high_voltage_mode,
   input wire logic                 high_freq_clock_running,
   input wire logic [EXT_LVL_W-1:0] external_supply_level_cfg,
   input wire logic                 main_regulator_switch_en,
   input wire logic                 high_voltage_regulator_switch_en,
   input wire logic                 power_down_req,
   input wire logic                 supply_drop_warning_app,
   input wire logic                 supply_drop_warning_net,
   input wire logic                 nvm_write_block,
   input wire logic [EXT_LVL_W-1:0] external_supply_level
);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic wr_main;
   logic wr_high;
   assign wr_main = psel && penable && pready && pwrite && paddr == OFS_MAIN_REG_SWITCH;
   assign wr_high = psel && penable && pready && pwrite && paddr == OFS_HIGH_REG_SWITCH;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   warn_twin_a: assert property (supply_drop_warning_app == supply_drop_warning_net)
      else $error("warning copies differ");
   warn_single_a: assert property (supply_drop_warning_app |=> !supply_drop_warning_app)
      else $error("warning longer than one cycle");
   block_on_warn_a: assert property (supply_drop_warning_app |-> nvm_write_block)
      else $error("warning without write block");
   off_quiet_a: assert property (power_down_req [*4] |=> !nvm_write_block && !supply_drop_warning_app)
      else $error("comparator active while powered down");
   clk_quiet_a: assert property (!high_freq_clock_running [*8] |=> !nvm_write_block && !supply_drop_warning_app)
      else $error("comparator active without fast clock");
   main_sw_cause_a: assert property ($rose(main_regulator_switch_en) |-> $past(wr_main))
      else $error("main switching enable set without its write");
   high_sw_cause_a: assert property ($rose(high_voltage_regulator_switch_en) |-> $past(wr_high))
      else $error("high switching enable set without its write");
   ext_follow_a: assert property (high_voltage_mode [*8] |=> external_supply_level == $past(external_supply_level_cfg))
      else $error("external level does not follow setting");
   ext_normal_a: assert property (!high_voltage_mode [*8] |=> external_supply_level == '0)
      else $error("external level driven in normal mode");
endmodule : rcr_regs_chk

bind rcr_regs rcr_regs_chk u_rcr_regs_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .high_voltage_mode, .high_freq_clock_running,
   .external_supply_level_cfg, .main_regulator_switch_en, .high_voltage_regulator_switch_en, .power_down_req,
   .supply_drop_warning_app, .supply_drop_warning_net, .nvm_write_block, .external_supply_level
);

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb
   import rcr_pkg::*;
;
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h00000000;
   logic [31:0]          prdata;
   logic                 pready, pslverr, irq, nvm_write_block, power_down_req;
   logic                 main_regulator_switch_en, radio_regulator_switch_en, high_voltage_regulator_switch_en;
   logic                 supply_drop_warning_app, supply_drop_warning_net;
   logic                 high_voltage_mode = 1'b0;
   logic                 high_freq_clock_running = 1'b1;
   logic [SUP_W-1:0]     supply_level = 7'h7f;
   logic [EXT_LVL_W-1:0] external_supply_level_cfg = 4'h0;
   logic [EXT_LVL_W-1:0] external_supply_level;
   logic [33:0]          expq[$];
   logic [33:0]          e;
   logic [31:0]          seed = 32'h0000ec0a;
   logic [11:0]          sw[3] = '{OFS_MAIN_REG_SWITCH, OFS_RADIO_REG_SWITCH, OFS_HIGH_REG_SWITCH};
   int                   mismatches = 0;
   int                   samples_checked = 0;
   int                   warn_cnt = 0;

   rcr_regs u_rcr_regs (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
      .high_voltage_mode, .high_freq_clock_running, .supply_level, .external_supply_level_cfg,
      .main_regulator_switch_en, .radio_regulator_switch_en, .high_voltage_regulator_switch_en, .power_down_req,
      .supply_drop_warning_app, .supply_drop_warning_net, .nvm_write_block, .external_supply_level, .irq
   );

   always #5 pclk = ~pclk;

   // ---------------------------------------------------------------
   // Bus driver and scoreboard
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
                      input logic err = 1'b0);
      expq.push_back({err, !wr, x});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         e = expq.pop_front();
         chk("pslverr", 32'(e[33]), 32'(pslverr));
         if (e[32]) chk("prdata", e[31:0], prdata);
      end
      if (supply_drop_warning_app === 1'b1) warn_cnt <= warn_cnt + 1;
   end

   // Threshold is met exactly first, then crossed by one step.
   task automatic probe(input logic hv, input logic [3:0] c, input logic [6:0] thr);
      int w;
      high_voltage_mode <= hv;
      supply_level <= thr;
      apb(1'b1, OFS_SUPPLY_DROP_CONFIG, {20'h0, c, 3'h0, c, 1'b1}, '0);
      wt(10);
      w = warn_cnt;
      chk("block at threshold", '0, 32'(nvm_write_block));
      supply_level <= thr - 7'h01;
      wt(10);
      chk("warnings", 32'h1, 32'(warn_cnt - w));
      chk("block", 32'h1, 32'(nvm_write_block));
      chk("masked irq", '0, 32'(irq));
      supply_level <= 7'h7f;
      wt(6);
   endtask : probe

   task automatic give_verdict();
      if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] d;
      int          w;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_MAIN_SUPPLY_STATUS, '0, '0);
      apb(1'b0, OFS_SUPPLY_DROP_CONFIG, '0, CFG_RST);
      for (int i = 0; i < 3; i++) apb(1'b0, sw[i], '0, '0);
      apb(1'b0, 12'h004, '0, '0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, sw[i], rnd() | 32'h1, '0);
         for (int j = 0; j < 3; j++) apb(1'b0, sw[j], '0, 32'(i == j));
         wt(1);
         chk("enables", 32'(3'b100 >> i), 32'({main_regulator_switch_en, radio_regulator_switch_en,
             high_voltage_regulator_switch_en}));
         apb(1'b1, sw[i], rnd() & 32'hfffffffe, '0);
      end
      repeat (4) begin
         d = rnd();
         apb(1'b1, OFS_SUPPLY_DROP_CONFIG, d, '0);
         apb(1'b0, OFS_SUPPLY_DROP_CONFIG, '0, d & CFG_MASK);
      end
      apb(1'b1, OFS_MAIN_SUPPLY_STATUS, '1, '0);
      apb(1'b0, OFS_MAIN_SUPPLY_STATUS, '0, '0);
      for (int c = 6; c < 16; c++) probe(1'b0, 4'(c), 7'(c + 13));
      high_voltage_mode <= 1'b1;
      external_supply_level_cfg <= 4'(rnd());
      wt(10);
      chk("level", 32'(external_supply_level_cfg), 32'(external_supply_level));
      apb(1'b0, OFS_MAIN_SUPPLY_STATUS, '0, 32'h1);
      apb(1'b0, OFS_IRQ_STATUS, '0, 32'h3);
      for (int c = 0; c < 16; c++) probe(1'b1, 4'(c), 7'(c + 27));
      high_voltage_mode <= 1'b0;
      wt(10);
      chk("level", '0, 32'(external_supply_level));
      apb(1'b0, OFS_IRQ_STATUS, '0, 32'h3);
      apb(1'b1, OFS_IRQ_MASK, 32'h1, '0);
      apb(1'b0, OFS_IRQ_MASK, '0, 32'h1);
      apb(1'b1, OFS_SUPPLY_DROP_CONFIG, 32'h1e, '0);
      supply_level <= 7'h14;
      wt(10);
      w = warn_cnt;
      chk("block", '0, 32'(nvm_write_block));
      apb(1'b1, OFS_SUPPLY_DROP_CONFIG, 32'h1f, '0);
      wt(10);
      chk("warnings", 32'h1, 32'(warn_cnt - w));
      chk("irq", 32'h1, 32'(irq));
      apb(1'b0, OFS_IRQ_STATUS, '0, 32'h1);
      wt(3);
      chk("irq", '0, 32'(irq));
      apb(1'b1, OFS_SUPPLY_DROP_CONFIG, 32'h0d, '0);
      wt(10);
      w = warn_cnt;
      apb(1'b1, OFS_SUPPLY_DROP_CONFIG, 32'h1f, '0);
      wt(10);
      chk("warnings", 32'h1, 32'(warn_cnt - w));
      supply_level <= 7'h7f;
      wt(10);
      w = warn_cnt;
      high_freq_clock_running <= 1'b0;
      supply_level <= 7'h14;
      wt(12);
      chk("warnings", '0, 32'(warn_cnt - w));
      chk("block", '0, 32'(nvm_write_block));
      high_freq_clock_running <= 1'b1;
      wt(10);
      chk("block", 32'h1, 32'(nvm_write_block));
      apb(1'b0, OFS_CMP_STATE, '0, 32'h3);
      apb(1'b1, OFS_POWER_DOWN_CONTROL, 32'h1, '0);
      wt(6);
      chk("power down", 32'h1, 32'(power_down_req));
      chk("block", '0, 32'(nvm_write_block));
      apb(1'b0, OFS_CMP_STATE, '0, 32'h0);
      apb(1'b0, OFS_POWER_DOWN_CONTROL, '0, '0);
      give_verdict();
   end

   initial begin
      #500000;
      mismatches++;
      give_verdict();
   end
endmodule : tb
